/* design/lpc_top.sv */
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lpc_defs.svh"
// How it works
// - three engines step programs independently
// - per-engine nine-bit driver map, any subset
// - one 96-word program store, free start addresses
// - 12-bit PWM duty, compensation adjusts it
// - 8-bit current setting register per driver
// - direct PWM per driver, or engine groups
// - test register write starts measurement, readable after
// - test source covers LEDs, supply, pump, event
// - auto gain watches only first six drivers
// - power-save whenever no output is active
// - low-phase flag while all outputs off but some duty is nonzero
// - linear temp slope, 31 signed settings
// - compensation continuous or only at wake
// - engines step on program clock rising edges
// - two-bit pump mode: off, 1x, 1.5x, auto
// - auto returns to 1x after 50 ms idle
// - engine value overrides direct PWM register
module lpc_top
    import lpc_pkg::*;
#(
    parameter int          PWM_DIV     = `LPC_PWM_DIV,
    parameter logic [31:0] CP_IDLE_CYC = `LPC_CP_IDLE_CYC
)(
    // Clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            sys_rst,
    // Register port
    input  wire logic [7:0]                      reg_addr,
    input  wire logic [15:0]                     reg_wdata,
    input  wire logic                            reg_we,
    input  wire logic                            reg_re,
    output logic      [15:0]                     reg_rdata,
    // Program clock pin and driver headroom comparators
    input  wire logic                            prog_clk,
    input  wire logic [`LPC_NUM_MON-1:0]         drv_sat,
    // On-chip temperature sensor, signed degrees C
    input  wire logic signed [7:0]               temp_c,
    // Test converter
    input  wire logic                            test_done,
    input  wire logic [7:0]                      test_result,
    output logic                                 test_start,
    output logic      [3:0]                      test_src,
    // Drivers and pump
    output logic      [`LPC_NUM_DRV-1:0]         led_current_outputs,
    output logic      [`LPC_NUM_DRV*8-1:0]       drv_current,
    output logic                                 cp_enable,
    output logic                                 cp_gain15,
    output logic                                 powersave,
    output logic                                 pwm_lowpower
);

    ////////////////////////////////////////////////////////////////////////////
    // Compensated duty: base + signed slope * temperature offset, clamped
    function automatic logic [11:0] tc_duty(input logic [11:0] base,
                                            input logic [4:0] slope,
                                            input logic signed [8:0] delta);
        logic signed [13:0] corr;
        logic signed [14:0] sum;
        corr = 14'(delta) * 14'($signed({1'b0, slope[3:0]}));
        if (slope[4])
            corr = -corr;
        sum = $signed({3'b000, base}) + 15'(corr);
        if (base == 12'h000)
            tc_duty = 12'h000;
        else if (sum < 0)
            tc_duty = 12'h000;
        else if (sum > 15'sd4095)
            tc_duty = 12'hfff;
        else
            tc_duty = sum[11:0];
    endfunction : tc_duty

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]                   pwm_ff [`LPC_NUM_DRV];
    logic [7:0]                   nxt_pwm [`LPC_NUM_DRV];
    logic [7:0]                   cur_ff [`LPC_NUM_DRV];
    logic [7:0]                   nxt_cur [`LPC_NUM_DRV];
    logic [`LPC_NUM_DRV-1:0]      map_ff [`LPC_NUM_ENG];
    logic [`LPC_NUM_DRV-1:0]      nxt_map [`LPC_NUM_ENG];
    logic [6:0]                   start_ff [`LPC_NUM_ENG];
    logic [6:0]                   nxt_start [`LPC_NUM_ENG];
    logic [`LPC_NUM_ENG-1:0]      eng_en_ff, nxt_eng_en;
    lpc_ctrl_t                    ctrl_ff, nxt_ctrl;
    logic [6:0]                   paddr_ff, nxt_paddr;
    logic [15:0]                  rdata_ff, nxt_rdata;
    lpc_tst_state_t               tst_ff, nxt_tst;
    logic [7:0]                   tres_ff, nxt_tres;
    logic [3:0]                   tsrc_ff, nxt_tsrc;
    logic                         tstart_ff, nxt_tstart;
    logic [15:0]                  prog_mem [`LPC_PROG_LAST+1];
    logic                         pwr_ff;
    logic                         cp_en_ff;
    logic                         gain_ff;

    // Register writes, reads and test control
    always_comb
    begin
        for (int i = 0; i < `LPC_NUM_DRV; i++)
        begin
            nxt_pwm[i] = pwm_ff[i];
            nxt_cur[i] = cur_ff[i];
            if (reg_we && reg_addr == `LPC_A_PWM + 8'(i))
                nxt_pwm[i] = reg_wdata[7:0];
            if (reg_we && reg_addr == `LPC_A_CUR + 8'(i))
                nxt_cur[i] = reg_wdata[7:0];
        end
        for (int e = 0; e < `LPC_NUM_ENG; e++)
        begin
            nxt_map[e] = map_ff[e];
            nxt_start[e] = start_ff[e];
            if (reg_we && reg_addr == `LPC_A_MAP + 8'(e))
                nxt_map[e] = reg_wdata[`LPC_NUM_DRV-1:0];
            if (reg_we && reg_addr == `LPC_A_START + 8'(e))
                nxt_start[e] = reg_wdata[6:0];
        end
        nxt_eng_en = eng_en_ff;
        if (reg_we && reg_addr == `LPC_A_ENG_EN)
            nxt_eng_en = reg_wdata[`LPC_NUM_ENG-1:0];
        nxt_ctrl = ctrl_ff;
        if (reg_we && reg_addr == `LPC_A_CTRL)
            nxt_ctrl = lpc_ctrl_t'(reg_wdata[`LPC_CTRL_W-1:0]);
        nxt_paddr = paddr_ff;
        if (reg_we && reg_addr == `LPC_A_PADDR)
            nxt_paddr = reg_wdata[6:0];
        else if (reg_we && reg_addr == `LPC_A_PDATA)
            nxt_paddr = (paddr_ff >= `LPC_PROG_LAST) ? 7'h00 : paddr_ff + 7'h01;
        // Test sequencing; a new write restarts a running test
        nxt_tst = tst_ff;
        nxt_tres = tres_ff;
        nxt_tsrc = tsrc_ff;
        nxt_tstart = 1'b0;
        unique case (tst_ff)
            TST_IDLE: ;
            TST_BUSY:
                if (test_done)
                begin
                    nxt_tres = test_result;
                    nxt_tst = TST_IDLE;
                end
        endcase
        if (reg_we && reg_addr == `LPC_A_TEST)
        begin
            nxt_tsrc = reg_wdata[3:0];
            nxt_tstart = 1'b1;
            nxt_tst = TST_BUSY;
        end
        // Read data, one cycle after the strobe
        nxt_rdata = 16'h0000;
        if (reg_re)
        begin
            for (int i = 0; i < `LPC_NUM_DRV; i++)
            begin
                if (reg_addr == `LPC_A_PWM + 8'(i))
                    nxt_rdata = {8'h00, pwm_ff[i]};
                if (reg_addr == `LPC_A_CUR + 8'(i))
                    nxt_rdata = {8'h00, cur_ff[i]};
            end
            for (int e = 0; e < `LPC_NUM_ENG; e++)
            begin
                if (reg_addr == `LPC_A_MAP + 8'(e))
                    nxt_rdata = {7'h00, map_ff[e]};
                if (reg_addr == `LPC_A_START + 8'(e))
                    nxt_rdata = {9'h000, start_ff[e]};
            end
            unique case (reg_addr)
                `LPC_A_ENG_EN: nxt_rdata = {13'h0000, eng_en_ff};
                `LPC_A_CTRL:   nxt_rdata = {6'h00, ctrl_ff};
                `LPC_A_STAT:   nxt_rdata = {12'h000, pwm_lowpower, cp_en_ff, gain_ff, pwr_ff};
                `LPC_A_TEST:   nxt_rdata = {tst_ff == TST_BUSY, 7'h00, tres_ff};
                `LPC_A_PADDR:  nxt_rdata = {9'h000, paddr_ff};
                default:       ;
            endcase
        end
    end

    // Register flops
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < `LPC_NUM_DRV; i++)
            begin
                pwm_ff[i] <= 8'h00;
                cur_ff[i] <= 8'h00;
            end
            for (int e = 0; e < `LPC_NUM_ENG; e++)
            begin
                map_ff[e] <= '0;
                start_ff[e] <= 7'h00;
            end
            eng_en_ff <= '0;
            ctrl_ff <= lpc_ctrl_t'(`LPC_CTRL_RST);
            paddr_ff <= 7'h00;
            rdata_ff <= 16'h0000;
            tst_ff <= TST_IDLE;
            tres_ff <= 8'h00;
            tsrc_ff <= 4'h0;
            tstart_ff <= 1'b0;
        end
        else
        begin
            pwm_ff <= nxt_pwm;
            cur_ff <= nxt_cur;
            map_ff <= nxt_map;
            start_ff <= nxt_start;
            eng_en_ff <= nxt_eng_en;
            ctrl_ff <= nxt_ctrl;
            paddr_ff <= nxt_paddr;
            rdata_ff <= nxt_rdata;
            tst_ff <= nxt_tst;
            tres_ff <= nxt_tres;
            tsrc_ff <= nxt_tsrc;
            tstart_ff <= nxt_tstart;
        end
    end

    // Program store, written through the data port
    always_ff @(posedge ref_clk)
    begin
        if (reg_we && reg_addr == `LPC_A_PDATA)
            prog_mem[paddr_ff] <= reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program clock sync and engines
    logic [2:0]  pclk_ff, nxt_pclk;
    lpc_eng_t    eng_ff [`LPC_NUM_ENG];
    lpc_eng_t    nxt_eng [`LPC_NUM_ENG];
    logic        tick;

    always_comb
    begin
        logic [15:0] instr;
        instr = 16'h0000;
        nxt_pclk = {pclk_ff[1:0], prog_clk};
        tick = pclk_ff[1] && !pclk_ff[2];
        for (int e = 0; e < `LPC_NUM_ENG; e++)
        begin
            nxt_eng[e] = eng_ff[e];
            if (!eng_en_ff[e])
            begin
                nxt_eng[e].pc = start_ff[e];
                nxt_eng[e].wait_cnt = 8'h00;
            end
            else if (tick)
            begin
                if (eng_ff[e].wait_cnt != 8'h00)
                    nxt_eng[e].wait_cnt = eng_ff[e].wait_cnt - 8'h01;
                else
                begin
                    instr = (eng_ff[e].pc <= `LPC_PROG_LAST) ? prog_mem[eng_ff[e].pc] : 16'h0000;
                    nxt_eng[e].value = instr[15:8];
                    if (instr[7:0] == 8'h00)
                        nxt_eng[e].pc = start_ff[e];
                    else
                    begin
                        nxt_eng[e].wait_cnt = instr[7:0];
                        nxt_eng[e].pc = (eng_ff[e].pc >= `LPC_PROG_LAST) ? 7'h00
                                        : eng_ff[e].pc + 7'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pclk_ff <= 3'h0;
            for (int e = 0; e < `LPC_NUM_ENG; e++)
                eng_ff[e] <= '0;
        end
        else
        begin
            pclk_ff <= nxt_pclk;
            eng_ff <= nxt_eng;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PWM, compensation, power-save and charge pump
    logic [7:0]                 div_ff, nxt_div;
    logic [11:0]                pcnt_ff, nxt_pcnt;
    logic [11:0]                duty [`LPC_NUM_DRV];
    logic [`LPC_NUM_DRV-1:0]    led_ff, nxt_led;
    logic signed [7:0]          tuse_ff, nxt_tuse;
    logic [`LPC_NUM_MON-1:0]    sat1_ff, sat2_ff;
    logic [31:0]                idle_ff, nxt_idle;
    logic                       nxt_pwr, nxt_cp_en, nxt_gain, lowp_ff, nxt_lowp, any_on;

    always_comb
    begin
        logic [7:0] sel;
        sel = 8'h00;
        nxt_div = (div_ff >= 8'(PWM_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
        nxt_pcnt = (div_ff >= 8'(PWM_DIV - 1)) ? pcnt_ff + 12'h001 : pcnt_ff;
        any_on = 1'b0;
        for (int d = 0; d < `LPC_NUM_DRV; d++)
        begin
            sel = pwm_ff[d];
            for (int e = `LPC_NUM_ENG - 1; e >= 0; e--)
                if (eng_en_ff[e] && map_ff[e][d])
                    sel = eng_ff[e].value;
            duty[d] = tc_duty({sel, sel[7:4]}, ctrl_ff.slope,
                              9'(tuse_ff) - 9'(`LPC_TEMP_REF));
            nxt_led[d] = pcnt_ff < duty[d];
            any_on = any_on || (duty[d] != 12'h000);
        end
        nxt_pwr = ctrl_ff.ps_en && !any_on;
        nxt_lowp = ctrl_ff.pwm_ps_en && any_on && (nxt_led == '0);
        // Continuous tracking, or one update when leaving power-save
        nxt_tuse = tuse_ff;
        if (!ctrl_ff.tc_single || (pwr_ff && !nxt_pwr))
            nxt_tuse = temp_c;
        nxt_idle = any_on ? 32'h0 : ((idle_ff > CP_IDLE_CYC) ? idle_ff : idle_ff + 32'h1);
        nxt_cp_en = ctrl_ff.charge_pump_gain_select != CP_OFF;
        nxt_gain = gain_ff;
        unique case (ctrl_ff.charge_pump_gain_select)
            CP_OFF:    nxt_gain = 1'b0;
            CP_BYPASS: nxt_gain = 1'b0;
            CP_BOOST:  nxt_gain = 1'b1;
            CP_AUTO:
                if (idle_ff > CP_IDLE_CYC)
                    nxt_gain = 1'b0;
                else if (|(sat2_ff & led_ff[`LPC_NUM_MON-1:0]))
                    nxt_gain = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            div_ff <= 8'h00;
            pcnt_ff <= 12'h000;
            led_ff <= '0;
            tuse_ff <= `LPC_TEMP_REF;
            sat1_ff <= '0;
            sat2_ff <= '0;
            idle_ff <= 32'h0;
            pwr_ff <= 1'b0;
            lowp_ff <= 1'b0;
            cp_en_ff <= 1'b0;
            gain_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            pcnt_ff <= nxt_pcnt;
            led_ff <= nxt_led;
            tuse_ff <= nxt_tuse;
            sat1_ff <= drv_sat;
            sat2_ff <= sat1_ff;
            idle_ff <= nxt_idle;
            pwr_ff <= nxt_pwr;
            lowp_ff <= nxt_lowp;
            cp_en_ff <= nxt_cp_en;
            gain_ff <= nxt_gain;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = rdata_ff;
    assign test_start = tstart_ff;
    assign test_src = tsrc_ff;
    assign led_current_outputs = led_ff;
    assign cp_enable = cp_en_ff;
    assign cp_gain15 = gain_ff;
    assign powersave = pwr_ff;
    assign pwm_lowpower = lowp_ff;
    // Current settings straight from their registers
    always_comb
        for (int i = 0; i < `LPC_NUM_DRV; i++)
            drv_current[i*8 +: 8] = cur_ff[i];

endmodule : lpc_top

/* design/lpc_defs.svh */
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH
// Register offsets
`define LPC_A_PWM     8'h00
`define LPC_A_CUR     8'h10
`define LPC_A_MAP     8'h20
`define LPC_A_START   8'h24
`define LPC_A_ENG_EN  8'h28
`define LPC_A_CTRL    8'h30
`define LPC_A_STAT    8'h31
`define LPC_A_TEST    8'h38
`define LPC_A_PADDR   8'h3c
`define LPC_A_PDATA   8'h3d
// Sizes
`define LPC_NUM_DRV   9
`define LPC_NUM_ENG   3
`define LPC_NUM_MON   6
`define LPC_PROG_LAST 7'h5f
// Timing
`define LPC_CLK_HZ    25000000
`define LPC_CP_IDLE_MS 50
`define LPC_CP_IDLE_CYC ((`LPC_CP_IDLE_MS * `LPC_CLK_HZ) / 1000)
`define LPC_PWM_HZ    312
`define LPC_PWM_DIV   (`LPC_CLK_HZ / (`LPC_PWM_HZ * 4096))
// Temperature reference point in degrees C
`define LPC_TEMP_REF  8'sd25
// Control field layout and reset value
`define LPC_CTRL_W    10
`define LPC_CTRL_RST  10'h000
`endif

/* design/lpc_pkg.sv */
package lpc_pkg;
    typedef enum logic [1:0] {
        CP_OFF    = 2'b00,
        CP_BYPASS = 2'b01,
        CP_BOOST  = 2'b10,
        CP_AUTO   = 2'b11
    } lpc_charge_pump_gain_select_t;

    typedef enum logic [1:0] {
        TST_IDLE = 2'b01,
        TST_BUSY = 2'b10
    } lpc_tst_state_t;

    // Control register layout, high bits first from the top
    typedef struct packed {
        logic [4:0]   slope;
        logic         tc_single;
        logic         pwm_ps_en;
        logic         ps_en;
        lpc_charge_pump_gain_select_t charge_pump_gain_select;
    } lpc_ctrl_t;

    // Per-engine run state
    typedef struct packed {
        logic [6:0] pc;
        logic [7:0] wait_cnt;
        logic [7:0] value;
    } lpc_eng_t;
endpackage : lpc_pkg

/* bench/lpc_conv_model.sv */
`timescale 1ns/1ps
module lpc_conv_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Conversion time in cycles, set by the bench
    input  wire logic [7:0] conv_delay,
    // Converter request
    input  wire logic       test_start,
    input  wire logic [3:0] test_src,
    // Converter answer
    output logic            test_done,
    output logic [7:0]      test_result
);
    logic [7:0] cnt_ff;
    logic [3:0] src_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Converter timer; result is only meaningful beside done
    always_ff @(posedge ref_clk)
    begin
        test_done   <= 1'b0;
        test_result <= ~test_result; // Stale value changes every cycle
        if (sys_rst)
        begin
            cnt_ff      <= 8'h00;
            test_result <= 8'h00;
        end
        else if (test_start)
        begin
            cnt_ff <= conv_delay;
            src_ff <= test_src;
        end
        else if (cnt_ff == 8'h01)
        begin
            cnt_ff      <= 8'h00;
            test_done   <= 1'b1;
            test_result <= {4'h5, src_ff};
        end
        else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
    end
endmodule : lpc_conv_model

/* bench/lpc_top_monitor.sv */
`timescale 1ns/1ps
`include "lpc_defs.svh"
module lpc_top_monitor
    import lpc_pkg::*;
#(
    parameter logic [31:0] CP_IDLE_CYC = `LPC_CP_IDLE_CYC
)(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_we,
    input wire logic        reg_re,
    input wire logic [15:0] reg_rdata,
    // Test, drivers and pump
    input wire logic        test_start,
    input wire logic [3:0]  test_src,
    input wire logic [8:0]  led_current_outputs,
    input wire logic [71:0] drv_current,
    input wire logic        cp_enable,
    input wire logic        cp_gain15,
    input wire logic        powersave,
    input wire logic        pwm_lowpower
);
    lpc_ctrl_t   ctrl_ff, nxt_ctrl;
    logic [31:0] idle_ff, nxt_idle;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control field and auto-pump idle time
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (reg_we && reg_addr == `LPC_A_CTRL)
            nxt_ctrl = lpc_ctrl_t'(reg_wdata[9:0]);
        nxt_idle = (ctrl_ff.charge_pump_gain_select == CP_AUTO && powersave) ? idle_ff + 32'h1 : 32'h0;
        if (sys_rst)
        begin
            nxt_ctrl = lpc_ctrl_t'(10'h000);
            nxt_idle = 32'h0;
        end
    end

    // Register the shadow state
    always_ff @(posedge ref_clk)
    begin
        ctrl_ff <= nxt_ctrl;
        idle_ff <= nxt_idle;
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_rdata_quiet: assert property (!$past(reg_re) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_test_launch: assert property (reg_we && reg_addr == `LPC_A_TEST
        |=> test_start && test_src == $past(reg_wdata[3:0]))
        else $error("test write did not launch measurement");
    a_test_cause: assert property (test_start
        |-> $past(reg_we && reg_addr == `LPC_A_TEST))
        else $error("test start without test write");
    a_pump_off: assert property ((ctrl_ff.charge_pump_gain_select == CP_OFF) [*3]
        |-> !cp_enable && !cp_gain15)
        else $error("pump not off");
    a_pump_bypass: assert property ((ctrl_ff.charge_pump_gain_select == CP_BYPASS) [*3]
        |-> cp_enable && !cp_gain15)
        else $error("pump not in 1x");
    a_pump_boost: assert property ((ctrl_ff.charge_pump_gain_select == CP_BOOST) [*3]
        |-> cp_enable && cp_gain15)
        else $error("pump not in 1.5x");
    a_pump_idle: assert property (idle_ff > CP_IDLE_CYC + 32'h8 |-> !cp_gain15)
        else $error("pump kept 1.5x after idle time");
    a_save_gate: assert property ((!ctrl_ff.ps_en) [*3] |-> !powersave)
        else $error("power-save while disabled");
    a_save_dark: assert property (powersave [*3] |-> led_current_outputs == 9'h000)
        else $error("outputs on during power-save");
    a_low_gate: assert property ((!ctrl_ff.pwm_ps_en) [*3] |-> !pwm_lowpower)
        else $error("low-phase saving while disabled");
    a_low_dark: assert property (pwm_lowpower [*2] |-> led_current_outputs == 9'h000)
        else $error("low-phase saving with outputs on");
    a_cur_reg: assert property (reg_we && reg_addr == `LPC_A_CUR
        |-> ##2 drv_current[7:0] == $past(reg_wdata[7:0], 2))
        else $error("current setting not applied");

    // Main scenarios
    c_test: cover property (test_start);
    c_boost: cover property ($rose(cp_gain15));
    c_low: cover property (pwm_lowpower);
endmodule : lpc_top_monitor

bind lpc_top lpc_top_monitor #(.CP_IDLE_CYC(CP_IDLE_CYC)) u_mon (.*);

/* bench/led_pattern_pwm_controller_test.sv */
`timescale 1ns/1ps
`include "lpc_defs.svh"
module led_pattern_pwm_controller_test
    import lpc_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] e;} lpc_row_t;
    localparam lpc_row_t ROWS [12] = '{
        '{8'h00, 16'h12ab, 16'h00ab}, '{8'h08, 16'h00ff, 16'h00ff},
        '{8'h10, 16'h1234, 16'h0034}, '{8'h18, 16'h00c5, 16'h00c5},
        '{8'h20, 16'hfe00, 16'h0000}, '{8'h21, 16'hfe00, 16'h0000},
        '{8'h24, 16'h00ff, 16'h007f}, '{8'h28, 16'hfff8, 16'h0000},
        '{8'h30, 16'hfc00, 16'h0000}, '{8'h31, 16'hffff, 16'h0000},
        '{8'h3d, 16'h1234, 16'h0000}, '{8'h3f, 16'hffff, 16'h0000}};
    localparam logic [15:0] TC_CTRL [5] = '{16'h0008, 16'h0028, 16'h0228, 16'h03e8, 16'h003c};
    localparam int          TC_T0 [5]   = '{25, 35, 35, 45, 35};
    localparam int          TC_T1 [5]   = '{25, 35, 35, 45, 45};
    localparam int          TC_D [5]    = '{2056, 2066, 2046, 1756, 2066};

    logic              ref_clk, sys_rst, reg_we, reg_re, prog_clk, test_done, test_start;
    logic              cp_enable, cp_gain15, powersave, pwm_lowpower;
    logic [7:0]        reg_addr, test_result, conv_delay, last;
    logic [15:0]       reg_wdata, reg_rdata;
    logic [5:0]        drv_sat;
    logic signed [7:0] temp_c;
    logic [3:0]        test_src;
    logic [8:0]        leds;
    logic [71:0]       drv_current;
    int                error_cnt, n_checks, on_n, lp_n, i, n;

    lpc_top #(.PWM_DIV(1), .CP_IDLE_CYC(32'h32)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .prog_clk(prog_clk),
        .drv_sat(drv_sat), .temp_c(temp_c), .test_done(test_done),
        .test_result(test_result), .test_start(test_start), .test_src(test_src),
        .led_current_outputs(leds), .drv_current(drv_current), .cp_enable(cp_enable),
        .cp_gain15(cp_gain15), .powersave(powersave), .pwm_lowpower(pwm_lowpower));

    lpc_conv_model conv (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .conv_delay(conv_delay),
        .test_start(test_start), .test_src(test_src), .test_done(test_done),
        .test_result(test_result));

    ////////////////////////////////////////////////////////////////////////////////
    // System clock and free-running program clock pin
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        prog_clk = 1'b0;
        forever #160 prog_clk = ~prog_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        #1 chk(32'(reg_rdata), 32'(e));
    endtask : rd

    // On-cycles and low-phase cycles over one PWM period
    task count_on(input int b);
        on_n = 0;
        lp_n = 0;
        repeat (4096)
        begin
            @(posedge ref_clk) #1;
            on_n += int'(leds[b]);
            lp_n += int'(pwm_lowpower);
        end
    endtask : count_on

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {sys_rst, reg_we, reg_re, reg_addr, reg_wdata} = {1'b1, 26'h0};
        {drv_sat, temp_c, conv_delay, last, error_cnt, n_checks} = {6'h00, 8'h19, 8'h01, 72'h0};
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1 chk({cp_enable, cp_gain15, powersave, pwm_lowpower, test_start, leds}, 32'h0);
        rd(`LPC_A_CTRL, 16'h0000);
        for (i = 0; i < 12; i++)
        begin
            wr(ROWS[i].a, ROWS[i].w);
            rd(ROWS[i].a, ROWS[i].e);
        end
        chk(32'({drv_current[71:64], drv_current[7:0]}), 32'hc534);
        $display("test registers done");
        for (i = 0; i < 12; i++)
        begin
            conv_delay <= i[0] ? 8'h28 : 8'h01;
            wr(`LPC_A_TEST, 16'(i));
            chk(32'({test_start, test_src}), 32'({1'b1, 4'(i)}));
            if (i[0])
                rd(`LPC_A_TEST, {8'h80, last});
            for (n = 0; n < 200 && test_done !== 1'b1; n++)
                @(posedge ref_clk) #1;
            chk(32'(test_done), 32'h1);
            if (test_done !== 1'b1)
                close_out;
            last = {4'h5, 4'(i)};
            rd(`LPC_A_TEST, {8'h00, last});
            rd(`LPC_A_TEST, {8'h00, last});
        end
        $display("test measurement done");
        for (i = 0; i < 3; i++)
        begin
            wr(`LPC_A_CTRL, 16'(2 - i));
            repeat (3) @(posedge ref_clk);
            #1 chk(32'({cp_enable, cp_gain15}), 32'({i != 2, i == 0}));
            rd(`LPC_A_STAT, {13'h0, i != 2, i == 0, 1'b0});
        end
        drv_sat <= 6'h3f;
        wr(`LPC_A_PWM, 16'h0000);
        wr(`LPC_A_CTRL, 16'h0007);
        repeat (40) @(posedge ref_clk);
        #1 chk(32'({cp_enable, cp_gain15, powersave}), 32'h4);
        wr(`LPC_A_PWM, 16'h00ff);
        for (n = 0; n < 100 && cp_gain15 !== 1'b1; n++)
            @(posedge ref_clk) #1;
        chk(32'(cp_gain15), 32'h1);
        wr(`LPC_A_PWM, 16'h0000);
        wr(`LPC_A_PWM + 8'h08, 16'h0000);
        repeat (30) @(posedge ref_clk);
        #1 chk(32'({cp_gain15, powersave}), 32'h3);
        repeat (50) @(posedge ref_clk);
        #1 chk(32'(cp_gain15), 32'h0);
        drv_sat <= 6'h00;
        $display("test pump done");
        for (i = 0; i < 5; i++)
        begin
            wr(`LPC_A_PWM + 8'h01, 16'h0000);
            wr(`LPC_A_CTRL, TC_CTRL[i]);
            temp_c <= 8'(TC_T0[i]);
            repeat (4) @(posedge ref_clk);
            wr(`LPC_A_PWM + 8'h01, 16'h0080);
            repeat (4) @(posedge ref_clk);
            temp_c <= 8'(TC_T1[i]);
            repeat (4100) @(posedge ref_clk);
            count_on(1);
            chk(32'(on_n), 32'(TC_D[i]));
            chk(32'(lp_n), 32'(4096 - TC_D[i]));
        end
        $display("test dimming done");
        wr(`LPC_A_CTRL, 16'h0000);
        temp_c <= 8'h19;
        wr(`LPC_A_PADDR, 16'h0000);
        wr(`LPC_A_PDATA, 16'h4000);
        wr(`LPC_A_PDATA, 16'h1000);
        wr(`LPC_A_PWM + 8'h02, 16'h00ff);
        wr(`LPC_A_MAP, 16'h0004);
        wr(`LPC_A_MAP + 8'h01, 16'h0008);
        wr(`LPC_A_START, 16'h0000);
        wr(`LPC_A_START + 8'h01, 16'h0001);
        wr(`LPC_A_ENG_EN, 16'h0003);
        repeat (4200) @(posedge ref_clk);
        count_on(2);
        chk(32'(on_n), 32'd1028);
        count_on(3);
        chk(32'(on_n), 32'd257);
        $display("test engines done");
        close_out;
    end
endmodule : led_pattern_pwm_controller_test
